/* File: design/osc_clock_switch.sv */
// Oscillator source selection, glitch-free switch and bus clock division
`timescale 1ns/10ps
`default_nettype none
module osc_clock_switch
  import osc_pkg::*;
#(
  parameter int unsigned EDGES = EDGE_CHECK        // Edges that prove activity
) (
  input  wire logic       clk_sys,                 // 40 MHz system clock
  input  wire logic       arst_n,                  // Async reset, active low
  input  wire logic [1:0] clock_source_select,     // Source code
  input  wire logic [1:0] crystal_range_select,    // Crystal amplifier range
  input  wire logic [1:0] internal_freq_select,    // Internal rate code
  input  wire logic [7:0] internal_osc_trim,       // Signed period trim
  input  wire logic       external_clock_request,  // Software switch request
  input  wire logic       osc_out_pin_enable,      // Output pin shows x4
  input  wire logic       keep_osc_in_stop,        // Keep running in stop
  input  wire logic       sim_osc_enable,          // Enable from integration unit
  input  wire logic       stop_mode,               // Device is in stop
  input  wire logic       clock_in_pin,            // Input pin level
  input  wire logic       port_out,                // Port data for output pin
  input  wire logic       port_oe,                 // Port drive for output pin
  output logic            clock_in_enable,         // Input pin owned as clock
  output logic            clock_out_pin_out,       // Output pin data
  output logic            clock_out_pin_oe,        // Output pin drive enable
  output logic            osc_out_pin_enable_eff,  // Enable as seen by the pin
  output logic [1:0]      xtal_amp_select,         // Active crystal amplifier
  output logic            external_clock_engaged,  // External source in use
  output logic            bus_clock_x4,            // Selected clock level
  output logic            bus_clock_x2             // Half of bus_clock_x4
);
  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (EDGES < 1 || EDGES > 7) begin : g_chk
    $error("EDGES must be 1 to 7");
  end

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Base step for the internal rate; reserved code runs at the fast rate
  function automatic logic [15:0] base_step(input logic [1:0] code);
    unique case (code)
      FRQ_LO:  base_step = STEP_LO;
      FRQ_MID: base_step = STEP_MID;
      default: base_step = STEP_HI;
    endcase
  endfunction : base_step

  logic               osc_active;     // Oscillator allowed to run
  logic        [15:0] step_base;      // Untrimmed step
  logic signed [24:0] trim_prod;      // Step times signed trim
  logic        [15:0] step_eff;       // Trimmed step
  logic               src_is_int;     // Internal source selected
  logic               src_is_xtal;    // Crystal source selected

  // Stop gating; wait mode has no effect here
  assign osc_active  = !stop_mode || sim_osc_enable || keep_osc_in_stop;
  assign src_is_int  = (clock_source_select == SRC_INT);
  assign src_is_xtal = (clock_source_select == SRC_XTAL);
  assign step_base   = base_step(internal_freq_select);
  // Larger trim shrinks the step, so the period grows
  assign trim_prod   = $signed({9'h000, step_base}) * $signed(internal_osc_trim);
  assign step_eff    = 16'(step_base - 16'(trim_prod >>> TRIM_SHIFT));

  // ****************************************************************
  // Internal oscillator model
  // ****************************************************************
  logic [ACC_W-1:0] acc_r, acc_nxt;   // Phase accumulator
  logic             int_x4_r, int_x4_nxt; // Internal clock level
  logic             int_run_r, int_run_nxt; // Internal oscillator running
  logic             pin_r, pin_nxt;   // Registered input pin
  logic             pin_q_r;          // Previous input pin sample
  logic [ACC_W:0]   acc_sum;          // Sum with carry

  // Phase advance; stopped oscillator holds its phase
  always_comb begin
    acc_sum    = {1'b0, acc_r} + {1'b0, step_eff};
    acc_nxt    = acc_r;
    int_x4_nxt = int_x4_r;
    pin_nxt    = clock_in_pin;
    if (int_run_r && osc_active) begin
      acc_nxt    = acc_sum[ACC_W-1:0];
      int_x4_nxt = int_x4_r ^ acc_sum[ACC_W];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_r    <= '0;
      int_x4_r <= 1'b0;
      pin_r    <= 1'b0;
      pin_q_r  <= 1'b0;
    end else begin
      acc_r    <= acc_nxt;
      int_x4_r <= int_x4_nxt;
      pin_r    <= pin_nxt;
      pin_q_r  <= pin_r;
    end
  end

  // ****************************************************************
  // Switch state machine
  // ****************************************************************
  sw_state_e  st_r, st_nxt;           // Switch state
  logic [2:0] edge_cnt_r, edge_cnt_nxt; // External rising edges seen
  logic       sel_ext_r, sel_ext_nxt; // Mux picks external level
  logic       x4_r, x4_nxt;           // Bus clock x4 level
  logic       x2_r, x2_nxt;           // Bus clock x2 level
  logic       all_low;                // Safe instant to change mux
  logic       ext_rise;               // Rising edge on input pin

  assign ext_rise = pin_r && !pin_q_r;
  // Changing the mux only while both sources and the output are low avoids runt pulses
  assign all_low  = !int_x4_r && !pin_r && !x4_r;

  always_comb begin
    st_nxt       = st_r;
    edge_cnt_nxt = edge_cnt_r;
    sel_ext_nxt  = sel_ext_r;
    int_run_nxt  = int_run_r;
    unique case (st_r)
      ST_INT: begin
        // Request only counts with an external source chosen
        if (external_clock_request && !src_is_int) begin
          st_nxt       = ST_CHECK;
          edge_cnt_nxt = '0;
        end
      end
      ST_CHECK: begin
        if (!external_clock_request || src_is_int) begin
          st_nxt = ST_INT;                 // Request withdrawn
        end else if (edge_cnt_r >= 3'(EDGES)) begin
          if (all_low) begin
            st_nxt      = ST_EXT;
            sel_ext_nxt = 1'b1;
          end
        end else if (ext_rise && osc_active) begin
          edge_cnt_nxt = edge_cnt_r + 3'h1;
        end
      end
      ST_EXT: begin
        int_run_nxt = 1'b0;
        if (!external_clock_request && src_is_int) begin
          st_nxt      = ST_BACK;
          int_run_nxt = 1'b1;
        end
      end
      ST_BACK: begin
        // Internal oscillator restarted; hand over at a low point
        if (all_low) begin
          st_nxt      = ST_INT;
          sel_ext_nxt = 1'b0;
        end
      end
    endcase
  end

  // Bus clock levels and division
  always_comb begin
    x4_nxt = x4_r;
    x2_nxt = x2_r;
    if (osc_active) begin
      x4_nxt = sel_ext_r ? pin_r : int_x4_r;
      if (x4_nxt && !x4_r) begin
        x2_nxt = !x2_r;
      end
    end
  end

  // Reset always lands on the internal oscillator
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= ST_INT;
      edge_cnt_r <= '0;
      sel_ext_r  <= 1'b0;
      int_run_r  <= 1'b1;
      x4_r       <= 1'b0;
      x2_r       <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      sel_ext_r  <= sel_ext_nxt;
      int_run_r  <= int_run_nxt;
      x4_r       <= x4_nxt;
      x2_r       <= x2_nxt;
    end
  end

  // ****************************************************************
  // Pin control
  // ****************************************************************
  logic out_r, out_nxt;               // Output pin data
  logic oe_r, oe_nxt;                 // Output pin enable
  logic en_eff;                       // Effective pin enable bit

  // Direct clock forces the enable clear; crystal ignores it
  assign en_eff = osc_out_pin_enable && (clock_source_select != SRC_EXT);

  always_comb begin
    out_nxt = port_out;
    oe_nxt  = port_oe;
    if (src_is_xtal) begin
      out_nxt = !clock_in_pin;
      oe_nxt  = 1'b1;
    end else if (en_eff) begin
      out_nxt = x4_r;
      oe_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // No interrupt or break-sensitive flag exists in this block
  assign clock_in_enable        = !src_is_int;
  assign clock_out_pin_out      = out_r;
  assign clock_out_pin_oe       = oe_r;
  assign osc_out_pin_enable_eff = en_eff && !src_is_xtal;
  assign xtal_amp_select        = crystal_range_select;
  assign external_clock_engaged = sel_ext_r;
  assign bus_clock_x4           = x4_r;
  assign bus_clock_x2           = x2_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_engage;
    $rose(sel_ext_r) ##0 int_run_r;
  endsequence
  sequence s_stop_int;
    ##1 !int_run_r;
  endsequence

  property p_half;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(x4_r) |-> x2_r != $past(x2_r);
  endproperty
  a_half: assert property (p_half) else $error("x2 did not toggle on x4 rise");

  property p_default;
    @(posedge clk_sys) disable iff (!arst_n)
      (internal_freq_select == FRQ_HI && internal_osc_trim == 8'h00) |-> step_eff == STEP_HI;
  endproperty
  a_default: assert property (p_default) else $error("fast rate step wrong");

  property p_trim;
    @(posedge clk_sys) disable iff (!arst_n)
      (!internal_osc_trim[7] && internal_osc_trim != 8'h00) |-> step_eff < step_base;
  endproperty
  a_trim: assert property (p_trim) else $error("positive trim did not slow clock");

  property p_check;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(sel_ext_r) |-> edge_cnt_r == 3'(EDGES);
  endproperty
  a_check: assert property (p_check) else $error("switched before edge count");

  property p_order;
    @(posedge clk_sys) disable iff (!arst_n)
      s_engage |-> s_stop_int;
  endproperty
  a_order: assert property (p_order) else $error("internal stopped out of order");

  property p_back;
    @(posedge clk_sys) disable iff (!arst_n)
      (st_r == ST_EXT && !external_clock_request && src_is_int) |-> ##[1:40] !sel_ext_r;
  endproperty
  a_back: assert property (p_back) else $error("no return to internal");

  property p_direct;
    @(posedge clk_sys) disable iff (!arst_n)
      clock_source_select == SRC_EXT |-> !osc_out_pin_enable_eff && clock_in_enable;
  endproperty
  a_direct: assert property (p_direct) else $error("direct mode pin enable set");

  property p_xtal;
    @(posedge clk_sys) disable iff (!arst_n)
      src_is_xtal |=> oe_r && out_r == !$past(clock_in_pin);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin not inverting");

  property p_x4out;
    @(posedge clk_sys) disable iff (!arst_n)
      (en_eff && !src_is_xtal) |=> oe_r && out_r == $past(x4_r);
  endproperty
  a_x4out: assert property (p_x4out) else $error("pin not showing x4");

  property p_stop;
    @(posedge clk_sys) disable iff (!arst_n)
      !osc_active |=> $stable(x4_r) && $stable(acc_r);
  endproperty
  a_stop: assert property (p_stop) else $error("clock ran while stopped");
endmodule : osc_clock_switch
`default_nettype wire

/* File: design/osc_pkg.sv */
// Constants and encodings for the oscillator clock switch
//
// Contract
// - bus_clock_x2 is half of bus_clock_x4
// - Internal 12.8/8/4 MHz, 12.8 default after reset
// - Signed trim; larger value gives longer period
// - External source enables input pin, crystal output
// - Count two external rising edges before switching
// - Set engaged first, then stop internal oscillator
// - Clearing source and request returns to internal
// - Direct clock feeds x4; pin enable forced clear
// - Crystal mode: output pin drives inverted input
// - Internal/RC: pin enable chooses port or x4
// - Internal mode releases input pin to port
// - No interrupts, no break-affected status flags
// - Runs in wait; in stop only if kept
// - Stop disable honoured unless keep overrides
// - Source codes: internal, direct, RC, crystal
// - Frequency codes 4/8/12.8 MHz, 11 reserved
// - Reset leaves internal oscillator in use
package osc_pkg;
  // ****************************************************************
  // Clock and accumulator figures
  // ****************************************************************
  localparam int unsigned CLK_SYS_KHZ = 40000;     // System clock rate
  localparam int unsigned ACC_W       = 16;        // Phase accumulator width
  localparam int unsigned TRIM_SHIFT  = 9;         // About 0.2 % per trim step
  localparam int unsigned F_HI_KHZ    = 12800;     // Fast internal rate
  localparam int unsigned F_MID_KHZ   = 8000;      // Middle internal rate
  localparam int unsigned F_LO_KHZ    = 4000;      // Slow internal rate
  // Phase step per system clock; the x4 level toggles twice per period
  localparam logic [15:0] STEP_HI  = 16'((F_HI_KHZ * 2 * 65536) / CLK_SYS_KHZ);
  localparam logic [15:0] STEP_MID = 16'((F_MID_KHZ * 2 * 65536) / CLK_SYS_KHZ);
  localparam logic [15:0] STEP_LO  = 16'((F_LO_KHZ * 2 * 65536) / CLK_SYS_KHZ);
  localparam int unsigned EDGE_CHECK = 2;          // External edges before switch

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] SRC_INT  = 2'h0;          // Internal oscillator
  localparam logic [1:0] SRC_EXT  = 2'h1;          // Direct external clock
  localparam logic [1:0] SRC_RC   = 2'h2;          // External RC
  localparam logic [1:0] SRC_XTAL = 2'h3;          // External crystal
  localparam logic [1:0] FRQ_LO   = 2'h0;          // 4.0 MHz
  localparam logic [1:0] FRQ_MID  = 2'h1;          // 8.0 MHz
  localparam logic [1:0] FRQ_HI   = 2'h2;          // 12.8 MHz, reset default

  typedef enum logic [1:0] {ST_INT, ST_CHECK, ST_EXT, ST_BACK} sw_state_e;
endpackage : osc_pkg

/* File: verif/sim_unit_model.sv */
// Integration unit model: stop control and bus clock from x2
`timescale 1ns/10ps
`default_nettype none
module integration_unit_model (
  input  wire logic clk_sys,        // System clock
  input  wire logic arst_n,         // Async reset, active low
  input  wire logic bus_clock_x2,   // Half rate clock from block
  input  wire logic stop_req,       // Bench asks for stop
  output logic      stop_mode,      // Stop state to block
  output logic      sim_osc_enable, // Dropped while stopped
  output logic      bus_clk_r       // Internal bus clock
);
  logic x2_r; // Previous x2 level
  // Enable falls in stop; the keep bit in the block may override
  assign stop_mode      = stop_req;
  assign sim_osc_enable = ~stop_req;
  // Divide x2 by two so the bus runs at a quarter of x4
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      x2_r      <= 1'b0;
      bus_clk_r <= 1'b0;
    end else begin
      x2_r <= bus_clock_x2;
      if (bus_clock_x2 && !x2_r) begin
        bus_clk_r <= ~bus_clk_r;
      end
    end
  end
endmodule : integration_unit_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the oscillator clock switch
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import osc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic       clk_sys  = 1'b0;    // 40 MHz clock
  logic       arst_n   = 1'b0;    // Reset, active low
  logic [1:0] src      = SRC_INT; // Source code
  logic [1:0] rng      = 2'h0;    // Crystal range
  logic [1:0] frq      = FRQ_HI;  // Internal rate code
  logic [7:0] trim     = 8'h00;   // Period trim
  logic       req      = 1'b0;    // Switch request
  logic       pin_en   = 1'b0;    // Output pin shows x4
  logic       keep     = 1'b0;    // Keep running in stop
  logic       stop_req = 1'b0;    // Stop request to model
  logic       pin      = 1'b0;    // Input pin level
  logic       port_out = 1'b0;    // Port data
  logic       port_oe  = 1'b0;    // Port drive
  logic       ext_run  = 1'b0;    // External clock on
  logic [2:0] ext_ph   = 3'h0;    // External clock phase
  logic       osc_run_en, stop_mode, bus_clk;      // Model outputs
  logic       in_en, out_d, out_oe, eff, eng, x4, x2; // Block outputs
  logic [1:0] amp;                // Amplifier select
  logic       p4, p2, pb, po;     // Previous levels
  int         n4, n2, nb, no;     // Rising edge counts
  int         fails    = 0;       // Mismatches
  int         compares = 0;       // Comparisons
  always #12.5 clk_sys = ~clk_sys;
  osc_clock_switch u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .clock_source_select(src),
    .crystal_range_select(rng), .internal_freq_select(frq), .internal_osc_trim(trim),
    .external_clock_request(req), .osc_out_pin_enable(pin_en), .keep_osc_in_stop(keep),
    .sim_osc_enable(osc_run_en), .stop_mode(stop_mode), .clock_in_pin(pin),
    .port_out(port_out), .port_oe(port_oe), .clock_in_enable(in_en),
    .clock_out_pin_out(out_d), .clock_out_pin_oe(out_oe), .osc_out_pin_enable_eff(eff),
    .xtal_amp_select(amp), .external_clock_engaged(eng), .bus_clock_x4(x4),
    .bus_clock_x2(x2));
  integration_unit_model u_integ (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_clock_x2(x2), .stop_req(stop_req),
    .stop_mode(stop_mode), .sim_osc_enable(osc_run_en), .bus_clk_r(bus_clk));
  // Edge counters; rates are judged from count differences
  always @(posedge clk_sys) begin
    p4 <= x4;
    p2 <= x2;
    pb <= bus_clk;
    po <= out_d;
    if (x4 && !p4) n4 <= n4 + 1;
    if (x2 && !p2) n2 <= n2 + 1;
    if (bus_clk && !pb) nb <= nb + 1;
    if (out_d && !po) no <= no + 1;
  end
  // External clock, eight cycles a period; pin low while stopped
  always @(negedge clk_sys) begin
    ext_ph <= ext_run ? ext_ph + 3'h1 : 3'h0;
    pin    <= ext_run & ext_ph[2];
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Counts are sampled, so a small tolerance absorbs phase
  task automatic chk_rate(input int got, input int exp, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rate
  task automatic rate(input int n, output int d4, output int d2, output int db,
                      output int dout);
    int a4, a2, ab, ao;
    a4 = n4;
    a2 = n2;
    ab = nb;
    ao = no;
    cyc(n);
    d4 = n4 - a4;
    d2 = n2 - a2;
    db = nb - ab;
    dout = no - ao;
  endtask : rate
  // Bounded wait for the engaged flag
  task automatic wait_eng(input logic lvl);
    for (int i = 0; i < 80 && eng !== lvl; i++) @(negedge clk_sys);
    chk(eng, lvl);
  endtask : wait_eng
  task automatic finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    int a, b, c, d;
    chk(eng, 1'b0);
    chk(in_en, 1'b0);
    rate(2000, a, b, c, d);
    chk_rate(a, 640, 3);
    chk_rate(b, 320, 3);
    chk_rate(c, 160, 3);
  endtask : t_reset
  task automatic t_freq;
    int e[4] = '{200, 400, 640, 640};
    int a, b, c, d;
    for (int i = 0; i < 4; i++) begin
      frq = 2'(i);
      cyc(20);
      rate(2000, a, b, c, d);
      chk_rate(a, e[i], 3);
    end
    frq = FRQ_HI;
    trim = 8'h7F;
    cyc(20);
    rate(2000, a, b, c, d);
    chk_rate(a, 482, 12);
    trim = 8'h80;
    cyc(20);
    rate(2000, a, b, c, d);
    chk_rate(a, 800, 12);
    trim = 8'h00;
  endtask : t_freq
  task automatic t_pin;
    int a, b, c, d;
    port_oe = 1'b1;
    port_out = 1'b1;
    cyc(4);
    chk(out_oe, 1'b1);
    chk(out_d, 1'b1);
    chk(eff, 1'b0);
    port_out = 1'b0;
    cyc(4);
    chk(out_d, 1'b0);
    pin_en = 1'b1;
    cyc(4);
    chk(eff, 1'b1);
    rate(2000, a, b, c, d);
    chk_rate(d, 640, 3);
    src = SRC_RC;
    cyc(4);
    chk(eff, 1'b1);
    chk(in_en, 1'b1);
    src = SRC_INT;
    pin_en = 1'b0;
    port_oe = 1'b0;
    cyc(4);
  endtask : t_pin
  // Request with internal source and live pin edges must not switch
  task automatic t_refuse;
    req = 1'b1;
    ext_run = 1'b1;
    cyc(60);
    chk(eng, 1'b0);
    chk(in_en, 1'b0);
    req = 1'b0;
    ext_run = 1'b0;
    cyc(4);
  endtask : t_refuse
  task automatic t_direct;
    int a, b, c, d;
    src = SRC_EXT;
    pin_en = 1'b1;
    cyc(40);
    chk(in_en, 1'b1);
    chk(eff, 1'b0);
    req = 1'b1;
    cyc(20);
    chk(eng, 1'b0);
    ext_run = 1'b1;
    // Switch cannot happen before this point; the pin is still high after its second rise
    cyc(16);
    chk(eng, 1'b0);
    wait_eng(1'b1);
    rate(800, a, b, c, d);
    chk_rate(a, 100, 2);
    chk_rate(b, 50, 2);
    req = 1'b0;
    cyc(20);
    chk(eng, 1'b1);
    src = SRC_INT;
    wait_eng(1'b0);
    ext_run = 1'b0;
    pin_en = 1'b0;
    cyc(20);
    rate(2000, a, b, c, d);
    chk_rate(a, 640, 3);
  endtask : t_direct
  task automatic t_xtal;
    port_oe = 1'b1;
    port_out = 1'b1;
    cyc(8);
    chk(out_d, 1'b1);
    src = SRC_XTAL;
    pin_en = 1'b1;
    ext_run = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rng = 2'(r);
      cyc(2);
      chk(amp, rng);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      #1;
      chk(out_d, !pin);
      chk(out_oe, 1'b1);
    end
    cyc(1);
    chk(eff, 1'b0);
    src = SRC_INT;
    ext_run = 1'b0;
    pin_en = 1'b0;
    port_oe = 1'b0;
    cyc(4);
  endtask : t_xtal
  task automatic t_stop;
    int a, b, c, d;
    stop_req = 1'b1;
    cyc(10);
    rate(400, a, b, c, d);
    chk_rate(a, 0, 0);
    keep = 1'b1;
    cyc(10);
    rate(2000, a, b, c, d);
    chk_rate(a, 640, 3);
    stop_req = 1'b0;
    keep = 1'b0;
    cyc(4);
  endtask : t_stop
  // Reset while engaged must land back on the internal oscillator
  task automatic t_rst_mid;
    int a, b, c, d;
    src = SRC_EXT;
    ext_run = 1'b1;
    cyc(40);
    req = 1'b1;
    wait_eng(1'b1);
    arst_n = 1'b0;
    src = SRC_INT;
    req = 1'b0;
    ext_run = 1'b0;
    cyc(10);
    chk(eng, 1'b0);
    arst_n = 1'b1;
    cyc(2);
    chk(in_en, 1'b0);
    rate(2000, a, b, c, d);
    chk_rate(a, 640, 3);
  endtask : t_rst_mid
  initial begin
    cyc(10);
    arst_n = 1'b1;
    cyc(2);
    t_reset;
    t_freq;
    t_pin;
    t_refuse;
    t_direct;
    t_xtal;
    t_stop;
    t_rst_mid;
    finish_test;
  end
  // Watchdog well past the expected run of about 0.6 ms
  initial begin
    #1500000;
    fails++;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
